//--- design/framer_defs.svh
// Purpose: constants for the clock reference packet framer
// Assumes: 188-byte transport packets, one byte per clock at most
// Notes: byte indices count from the sync byte at index 0
`ifndef FRAMER_DEFS_SVH
`define FRAMER_DEFS_SVH

`define SYNC_BYTE 8'h47
`define FILL_BYTE 8'hff
`define AF_LEN_BYTE 8'h07
`define AF_FLAGS_BYTE 8'h10
`define POINTER_BYTE 8'h00
`define AFC_ONLY 2'b10
`define AFC_BOTH 2'b11
`define PCR_RESERVED 6'h3f
`define POINTER_IDX 8'd12
`define LAST_IDX 8'd187
`define FIFO_DEPTH 8
`define FIFO_WIDTH 9

`endif

//--- design/framer_pkg.sv
// Purpose: types for the clock reference packet framer
// Assumes: constants live in framer_defs.svh
// Notes: state codes step in Gray order along the payload path idle, head, section, fill, idle
package framer_pkg;

  typedef logic [1:0] scramble_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HEAD = 3'b001,
    ST_SECT = 3'b011,
    ST_FILL = 3'b010,
    ST_FLUSH = 3'b110
  } state_type;

  typedef struct packed {
    state_type st;
    logic [7:0] idx;
    logic pay;
    logic [12:0] pid;
    scramble_type scr;
    logic [3:0] cc;
    logic [32:0] base;
    logic [8:0] ext;
    logic [7:0] data;
    logic valid;
    logic ovf;
  } framer_type;

endpackage : framer_pkg

//--- design/ncr_pcr_insertion_framer.sv
// Purpose: builds 188-byte packets carrying the network clock count
// Assumes: section bytes arrive through the fifo, last byte flagged
// Notes: start is taken only while idle; output stalls on ts_ready_i
`timescale 1ns/1ns
`include "framer_defs.svh"

// small ring buffer, DEPTH a power of two
module section_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_type;

  fifo_type s;
  fifo_type next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // honest full and empty from the wrap bit
  assign in_ready_o = !((s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]));
  assign out_valid_o = (s.wr != s.rd);
  assign out_data_o = mem[s.rd[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wr = s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = s.rd + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // storage, no reset needed
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[s.wr[AW-1:0]] <= in_data_i;
    end
  end
endmodule : section_fifo

module ncr_pcr_insertion_framer #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic with_payload_i,
  input wire logic [12:0] pid_i,
  input wire framer_pkg::scramble_type scramble_i,
  input wire logic [32:0] pcr_base_i,
  input wire logic [8:0] pcr_ext_i,
  input wire logic [7:0] sec_data_i,
  input wire logic sec_last_i,
  input wire logic sec_valid_i,
  output logic sec_ready_o,
  output logic [7:0] ts_data_o,
  output logic ts_valid_o,
  output logic ts_sop_o,
  output logic ts_last_o,
  input wire logic ts_ready_i,
  output logic busy_o,
  output logic overflow_o
);
  import framer_pkg::*;

  framer_type s;
  framer_type next_s;
  logic load;
  logic pop;
  logic [`FIFO_WIDTH-1:0] fifo_data;
  logic fifo_valid;
  logic [7:0] next_idx;

  // fixed header and adaptation bytes, index 0 to 11
  function automatic logic [7:0] head_byte(input logic [7:0] idx, input framer_type f);
    logic [7:0] b;
    b = `SYNC_BYTE;
    unique case (idx)
      8'd1: b = {1'b0, f.pay, 1'b0, f.pid[12:8]};
      8'd2: b = f.pid[7:0];
      8'd3: b = {f.scr, (f.pay ? `AFC_BOTH : `AFC_ONLY), f.cc};
      8'd4: b = `AF_LEN_BYTE;
      8'd5: b = `AF_FLAGS_BYTE;
      8'd6: b = f.base[32:25];
      8'd7: b = f.base[24:17];
      8'd8: b = f.base[16:9];
      8'd9: b = f.base[8:1];
      8'd10: b = {f.base[0], `PCR_RESERVED, f.ext[8]};
      8'd11: b = f.ext[7:0];
      default: b = `SYNC_BYTE;
    endcase
    return b;
  endfunction : head_byte

  // section bytes buffered ahead of the packet
  section_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .in_data_i({sec_last_i, sec_data_i}),
    .in_valid_i(sec_valid_i),
    .in_ready_o(sec_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop)
  );

  // output byte register advances when empty or taken
  assign load = !s.valid || ts_ready_i;
  assign next_idx = s.idx + 8'd1;

  always_comb begin
    next_s = s;
    next_s.ovf = 1'b0;
    pop = 1'b0;
    unique case (s.st)
      ST_IDLE: begin
        if (load) begin
          next_s.valid = 1'b0;
          if (start_i) begin
            next_s.pay = with_payload_i;
            next_s.pid = pid_i;
            next_s.scr = scramble_i;
            next_s.base = pcr_base_i;
            next_s.ext = pcr_ext_i;
            next_s.cc = with_payload_i ? s.cc + 4'd1 : s.cc;
            next_s.data = `SYNC_BYTE;
            next_s.valid = 1'b1;
            next_s.idx = 8'd0;
            next_s.st = ST_HEAD;
          end
        end
      end
      ST_HEAD: begin
        if (load) begin
          next_s.idx = next_idx;
          next_s.valid = 1'b1;
          next_s.data = head_byte(next_idx, s);
          if (next_idx == `POINTER_IDX) begin
            if (s.pay) begin
              next_s.data = `POINTER_BYTE;
              next_s.st = ST_SECT;
            end else begin
              next_s.data = `FILL_BYTE;
              next_s.st = ST_FILL;
            end
          end
        end
      end
      ST_SECT: begin
        pop = load;
        if (load) begin
          next_s.valid = fifo_valid;
          if (fifo_valid) begin
            next_s.data = fifo_data[7:0];
            next_s.idx = next_idx;
            if (next_idx == `LAST_IDX) begin
              next_s.st = fifo_data[8] ? ST_IDLE : ST_FLUSH;
              next_s.ovf = !fifo_data[8];
            end else if (fifo_data[8]) begin
              next_s.st = ST_FILL;
            end
          end
        end
      end
      ST_FILL: begin
        if (load) begin
          next_s.data = `FILL_BYTE;
          next_s.valid = 1'b1;
          next_s.idx = next_idx;
          if (next_idx == `LAST_IDX) begin
            next_s.st = ST_IDLE;
          end
        end
      end
      ST_FLUSH: begin
        pop = 1'b1;
        if (load) begin
          next_s.valid = 1'b0;
        end
        if (fifo_valid && fifo_data[8]) begin
          next_s.st = ST_IDLE;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
        next_s.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign ts_data_o = s.data;
  assign ts_valid_o = s.valid;
  assign ts_sop_o = s.valid && (s.idx == 8'd0);
  assign ts_last_o = s.valid && (s.idx == `LAST_IDX);
  assign busy_o = (s.st != ST_IDLE);
  assign overflow_o = s.ovf;

  // adaptation-only code without payload
  afc_only_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    s.valid && s.idx == 8'd3 && !s.pay |-> s.data[5:4] == 2'b10)
    else $error("afc not 10 in clock-only packet");

  // adaptation plus payload code
  afc_both_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    s.valid && s.idx == 8'd3 && s.pay |-> s.data[5:4] == 2'b11)
    else $error("afc not 11 in payload packet");

  // no payload bytes in clock-only packet
  no_payload_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    s.valid && !s.pay && s.idx >= 8'd12 |-> s.data == 8'hff)
    else $error("payload byte in clock-only packet");

  // start flag and pointer go together
  pointer_field_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    s.valid && (s.idx == 8'd1 || (s.pay && s.idx == 8'd12)) |->
      ((s.idx == 8'd1) ? (s.data[6] == s.pay) : (s.data == 8'h00 && s.st == ST_SECT)))
    else $error("pointer or start flag wrong");

  // error and priority bits stay low
  header_zero_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    s.valid && s.idx == 8'd1 |-> s.data[7] == 1'b0 && s.data[5] == 1'b0)
    else $error("error or priority bit set");

  // identifier high bits and low byte follow sampled value
  pid_field_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    s.valid && (s.idx == 8'd1 || s.idx == 8'd2) |->
      ((s.idx == 8'd1) ? (s.data[4:0] == s.pid[12:8]) : (s.data == s.pid[7:0])))
    else $error("pid bytes do not match");

  // adaptation length and flags
  af_fixed_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    s.valid && (s.idx == 8'd4 || s.idx == 8'd5) |->
      (s.data == ((s.idx == 8'd4) ? 8'h07 : 8'h10)))
    else $error("adaptation length or flags wrong");

  // clock count base and extension sampled at start
  pcr_top_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    s.st == ST_IDLE && load && start_i |=> s.base == $past(pcr_base_i) &&
      s.ext == $past(pcr_ext_i))
    else $error("clock count not sampled");

  // last byte at 188th position
  packet_end_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    ts_last_o && ts_ready_i |=> !s.valid || s.idx == 8'd0)
    else $error("packet did not end at byte 187");

  // stalled byte holds
  hold_stall_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    s.valid && !ts_ready_i |=> s.valid && $stable(s.data) && $stable(s.idx))
    else $error("output changed while stalled");

  // truncated section is drained, not sent
  flush_quiet_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    s.st == ST_FLUSH && load |=> !s.valid)
    else $error("byte sent after section overflow");
endmodule : ncr_pcr_insertion_framer

//--- verif/tb_top.sv
// Purpose: self-checking bench for the clock reference framer
// Assumes: section bytes fed through the fifo port, consumer model stalls
// Notes: expected bytes are rebuilt here from the field layout
`timescale 1ns/1ns
module tb_top;
  import framer_pkg::*;
  typedef struct {
    logic pay;
    logic [12:0] pid;
    scramble_type scr;
    logic [32:0] base;
    logic [8:0] ext;
    int len;
    bit stall;
  } row_type;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic start_i = 1'b0;
  logic with_payload_i = 1'b0;
  logic [12:0] pid_i = 13'h0000;
  scramble_type scramble_i = 2'h0;
  logic [32:0] pcr_base_i = 33'h000000000;
  logic [8:0] pcr_ext_i = 9'h000;
  logic [7:0] sec_data_i = 8'h00;
  logic sec_last_i = 1'b0;
  logic sec_valid_i = 1'b0;
  logic sec_ready_o, ts_valid_o, ts_sop_o, ts_last_o, ts_ready_i, busy_o, overflow_o;
  logic [7:0] ts_data_o;
  logic stall = 1'b0;
  logic [7:0] sec_mem [0:199];
  int sec_len = 0;
  int sec_pos = 0;
  int mismatches = 0;
  int checked = 0;
  int ovf = 0;
  int cc = 0;
  row_type rows [4] = '{
    '{1'b0, 13'h0000, 2'h0, 33'h000000000, 9'h000, 0, 1'b0},
    '{1'b1, 13'h1fff, 2'h3, 33'h1ffffffff, 9'h1ff, 175, 1'b1},
    '{1'b1, 13'h0abc, 2'h2, 33'h0a5c3e17b, 9'h155, 1, 1'b0},
    '{1'b0, 13'h1234, 2'h1, 33'h123456789, 9'h0aa, 0, 1'b1}};
  always #25 ref_clk_i = ~ref_clk_i;
  ncr_pcr_insertion_framer ncr_pcr_insertion_framer_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .start_i(start_i), .with_payload_i(with_payload_i), .pid_i(pid_i), .scramble_i(scramble_i),
    .pcr_base_i(pcr_base_i), .pcr_ext_i(pcr_ext_i), .sec_data_i(sec_data_i),
    .sec_last_i(sec_last_i), .sec_valid_i(sec_valid_i), .sec_ready_o(sec_ready_o),
    .ts_data_o(ts_data_o), .ts_valid_o(ts_valid_o), .ts_sop_o(ts_sop_o), .ts_last_o(ts_last_o),
    .ts_ready_i(ts_ready_i), .busy_o(busy_o), .overflow_o(overflow_o));
  ts_sink ts_sink_i (.ref_clk_i(ref_clk_i), .stall_i(stall), .ts_data_i(ts_data_o),
    .ts_valid_i(ts_valid_o), .ts_sop_i(ts_sop_o), .ts_last_i(ts_last_o), .ts_ready_o(ts_ready_i));
  // section feeder, holds each byte until taken
  always @(posedge ref_clk_i) begin
    if (sec_valid_i && sec_ready_o) sec_pos++;
    #5;
    sec_valid_i = sec_pos < sec_len;
    sec_data_i = sec_mem[sec_pos % 200];
    sec_last_i = sec_pos == sec_len - 1;
  end
  // count overflow pulses
  always @(posedge ref_clk_i) begin
    if (overflow_o === 1'b1) ovf++;
  end
  task automatic step;
    @(posedge ref_clk_i);
    #5;
  endtask : step
  task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic test_done;
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  // one packet: feed section, start, wait, compare every byte
  task automatic run_pkt(input row_type r, input bit poke);
    int k;
    int t0;
    logic [7:0] e;
    for (k = 0; k < 400 && busy_o !== 1'b0; k++) step;
    if (k == 400) begin
      mismatches++;
      test_done;
    end
    with_payload_i = r.pay;
    pid_i = r.pid;
    scramble_i = r.scr;
    pcr_base_i = r.base;
    pcr_ext_i = r.ext;
    stall = r.stall;
    for (k = 0; k < 200; k++) sec_mem[k] = 8'(k * 7 + 1) ^ r.pid[7:0];
    sec_pos = 0;
    sec_len = r.len;
    if (r.pay) begin
      cc++;
      repeat (12) step;
      chk("fifo_full", 33'(r.len < 8), 33'(sec_ready_o));
    end
    t0 = ts_sink_i.tot;
    start_i = 1'b1;
    for (k = 0; k < 2000 && ts_sink_i.tot < t0 + 188; k++) begin
      step;
      start_i = poke && k == 50;
    end
    start_i = 1'b0;
    if (k == 2000) begin
      mismatches++;
      test_done;
    end
    for (k = 0; k < 188; k++) begin
      if (k == 0) e = 8'h47;
      else if (k == 1) e = {1'b0, r.pay, 1'b0, r.pid[12:8]};
      else if (k == 2) e = r.pid[7:0];
      else if (k == 3) e = {r.scr, 1'b1, r.pay, 4'(cc)};
      else if (k == 4) e = 8'h07;
      else if (k == 5) e = 8'h10;
      else if (k < 10) e = r.base[32 - 8 * (k - 6) -: 8];
      else if (k == 10) e = {r.base[0], 6'h3f, r.ext[8]};
      else if (k == 11) e = r.ext[7:0];
      else if (k == 12) e = r.pay ? 8'h00 : 8'hff;
      else e = (r.pay && k - 13 < r.len) ? sec_mem[k - 13] : 8'hff;
      chk($sformatf("byte%0d", k), 33'(e), 33'(ts_sink_i.pkt[k]));
    end
    chk("framing", 33'h0, 33'(ts_sink_i.bad));
  endtask : run_pkt
  initial begin
    row_type big;
    repeat (2) @(posedge ref_clk_i);
    #5;
    chk("rst_valid", 33'h0, 33'(ts_valid_o));
    chk("rst_busy", 33'h0, 33'(busy_o));
    chk("rst_ready", 33'h1, 33'(sec_ready_o));
    chk("rst_ovf", 33'h0, 33'(overflow_o));
    repeat (2) @(posedge ref_clk_i);
    #5;
    nrst_i = 1'b1;
    foreach (rows[i]) run_pkt(rows[i], 1'b0);
    // oversize section with a start poked mid packet
    big = '{1'b1, 13'h0101, 2'h1, 33'h0f0f0f0f0, 9'h0f0, 180, 1'b1};
    run_pkt(big, 1'b1);
    repeat (200) step;
    chk("overflow", 33'h1, 33'(ovf));
    chk("ignored", 33'(188 * 5), 33'(ts_sink_i.tot));
    chk("idle", 33'h0, 33'(busy_o));
    chk("drained", 33'h1, 33'(sec_ready_o));
    // reset dropped in mid packet, then released while idle
    with_payload_i = 1'b0;
    start_i = 1'b1;
    step;
    start_i = 1'b0;
    repeat (20) step;
    chk("mid_busy", 33'h1, 33'(busy_o));
    nrst_i = 1'b0;
    step;
    chk("rst2_valid", 33'h0, 33'(ts_valid_o));
    chk("rst2_busy", 33'h0, 33'(busy_o));
    chk("rst2_ready", 33'h1, 33'(sec_ready_o));
    nrst_i = 1'b1;
    repeat (2) step;
    chk("rel_valid", 33'h0, 33'(ts_valid_o));
    chk("rel_busy", 33'h0, 33'(busy_o));
    chk("rel_ovf", 33'h0, 33'(overflow_o));
    test_done;
  end
endmodule : tb_top

//--- verif/ts_sink.sv
// Purpose: consumer model of the packet stream, keeps the last packet
// Assumes: one byte per handshake, 188-byte packets
// Notes: stall holds ready low two cycles of three
`timescale 1ns/1ns
module ts_sink (
  input wire logic ref_clk_i,
  input wire logic stall_i,
  input wire logic [7:0] ts_data_i,
  input wire logic ts_valid_i,
  input wire logic ts_sop_i,
  input wire logic ts_last_i,
  output logic ts_ready_o
);
  logic [7:0] pkt [0:187];
  int tot = 0;
  int bad = 0;
  int cyc = 0;
  initial ts_ready_o = 1'b1;
  // take a byte on handshake, count framing slips
  always @(posedge ref_clk_i) begin
    if (ts_valid_i && ts_ready_o) begin
      pkt[tot % 188] = ts_data_i; // pointer byte kept as sent
      if (ts_sop_i !== (tot % 188 == 0) || ts_last_i !== (tot % 188 == 187)) begin
        bad++;
      end
      tot++;
    end
    cyc++;
    #5;
    ts_ready_o = !stall_i || (cyc % 3 == 0);
  end
endmodule : ts_sink
